//--- src/tbf_pkg.sv
// Package of constants and carriers for the tape block formatter
package tbf_pkg;

  // ----------------------------------------------------------------
  // Clock and tape geometry
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  // Head travel assumed at 100 inches per second: one mil of tape per 10 us
  localparam int CYC_PER_MIL = 200;
  // Lengths in thousandths of an inch, figures as printed
  localparam int PE_GAP_NOM_MIL   = 600;
  localparam int PE_GAP_MIN_MIL   = 500;
  localparam int GCR_GAP_NOM_MIL  = 300;
  localparam int GCR_GAP_MIN_MIL  = 285;
  localparam int GCR_TM_GAP_MIL   = 3300;
  localparam int PE_INIT_GAP_MIL  = 3000;
  localparam int PE_EMPTY_MIL     = 25 * 12 * 1000;
  localparam int GCR_EMPTY_MIL    = 15 * 12 * 1000;
  localparam int ARA_ID_MIL       = 2000;
  // Cycle counts derived from the lengths
  localparam int PE_GAP_CYC      = PE_GAP_NOM_MIL * CYC_PER_MIL;
  localparam int GCR_GAP_CYC     = GCR_GAP_NOM_MIL * CYC_PER_MIL;
  localparam int GCR_TM_GAP_CYC  = GCR_TM_GAP_MIL * CYC_PER_MIL;
  localparam int PE_INIT_GAP_CYC = PE_INIT_GAP_MIL * CYC_PER_MIL;
  localparam int PE_EMPTY_CYC    = PE_EMPTY_MIL * CYC_PER_MIL;
  localparam int GCR_EMPTY_CYC   = GCR_EMPTY_MIL * CYC_PER_MIL;
  localparam int ARA_ID_CYC      = ARA_ID_MIL * CYC_PER_MIL;

  // ----------------------------------------------------------------
  // Framing counts
  // ----------------------------------------------------------------
  localparam int PE_PRE_ZEROS   = 40;
  localparam int GCR_PRE_BYTES  = 16 * 5;
  localparam int GCR_GRP_DATA   = 7;
  localparam int GCR_MAX_GROUPS = 158;
  localparam int GCR_RESYNC_BYTES = 1112;
  localparam int TM_FLUX_COUNT  = 300;

  // ----------------------------------------------------------------
  // Track patterns, bit n-1 is physical track n
  // ----------------------------------------------------------------
  localparam logic [8:0] TRK_ERASED  = 9'h000;
  localparam logic [8:0] TRK_ALL     = 9'h1ff;
  localparam logic [8:0] TRK_GCR_ID  = 9'h020;
  localparam logic [8:0] TRK_ARA_ID  = 9'h1b6;
  localparam logic [8:0] TRK_ZONE1   = 9'h049;
  localparam logic [8:0] TRK_ZONE2   = 9'h092;
  localparam logic [8:0] TRK_ZONE3   = 9'h124;
  localparam logic [8:0] TRK_RESYNC  = 9'h1ff;
  localparam int         TM_ZONE2_MIN = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {TBF_CMD_WRITE, TBF_CMD_ERASE_GAP, TBF_CMD_MARK, TBF_CMD_BOT}
    tbf_cmd_e;
  typedef enum logic {TBF_MODE_PE, TBF_MODE_GCR} tbf_mode_e;

  typedef struct packed {
    logic       valid;
    tbf_cmd_e   cmd;
    logic [15:0] length;
  } tbf_cmd_s;

  typedef struct packed {
    logic       valid;
    logic [8:0] tracks;
    logic       is_ecc;
  } tbf_char_s;

endpackage

//--- src/tbf_tape_reader.sv
// Read-side monitor: empty tape and tape mark detection
`timescale 1ns/1ps
`default_nettype none
module tbf_tape_reader
  import tbf_pkg::*;
#(
  parameter int PE_EMPTY  = PE_EMPTY_CYC,
  parameter int GCR_EMPTY = GCR_EMPTY_CYC
)(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // Control
  input  wire logic       rd_active_i,
  input  var  tbf_mode_e  mode_i,
  // Head read characters
  input  wire logic       rd_strobe_i,
  input  wire logic [8:0] rd_tracks_i,
  input  wire logic       rd_flux_i,
  // Status
  output logic            empty_tape_o,
  output logic            tape_mark_o
);

  logic [31:0] erase_reg, erase_next;
  logic        empty_reg, empty_next;
  logic [3:0]  z2_reg, z2_next;
  logic        mark_reg, mark_next;
  logic [31:0] limit;
  logic        z1_act, z2_act, z3_clr;

  assign limit  = (mode_i == TBF_MODE_PE) ? 32'(PE_EMPTY) : 32'(GCR_EMPTY);
  assign z1_act = |(rd_tracks_i & TRK_ZONE1);
  assign z2_act = |(rd_tracks_i & TRK_ZONE2);
  assign z3_clr = ~|(rd_tracks_i & TRK_ZONE3);

  always_comb
  begin
    erase_next = erase_reg;
    empty_next = empty_reg;
    z2_next    = z2_reg;
    mark_next  = 1'b0;
    if (!rd_active_i)
    begin
      erase_next = '0;
      empty_next = 1'b0;
      z2_next    = '0;
    end
    else
    begin
      if (rd_flux_i)
        erase_next = '0;
      else if (erase_reg <= limit)
        erase_next = erase_reg + 32'd1;
      if (erase_reg > limit)
        empty_next = 1'b1;
      if (rd_strobe_i)
      begin
        if (z3_clr && z1_act && z2_act && z2_reg < 4'(TM_ZONE2_MIN))
          z2_next = z2_reg + 4'd1;
        else if (!(z3_clr && z1_act))
          z2_next = '0;
        if (z3_clr && z1_act && (!z2_act || z2_reg + 4'd1 >= 4'(TM_ZONE2_MIN)))
          mark_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      erase_reg <= '0;
      empty_reg <= 1'b0;
      z2_reg    <= '0;
      mark_reg  <= 1'b0;
    end
    else
    begin
      erase_reg <= erase_next;
      empty_reg <= empty_next;
      z2_reg    <= z2_next;
      mark_reg  <= mark_next;
    end
  end

  assign empty_tape_o = empty_reg;
  assign tape_mark_o  = mark_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_mark_needs_z3_erased;
    @(posedge clk_i) disable iff (reset_i)
      tape_mark_o |-> $past(z3_clr && z1_act && rd_strobe_i);
  endproperty
  a_mark_needs_z3_erased: assert property (p_mark_needs_z3_erased)
    else $error("tape mark reported without zone 3 erased");

  property p_empty_only_after_limit;
    @(posedge clk_i) disable iff (reset_i)
      $rose(empty_tape_o) |-> $past(erase_reg) > $past(limit);
  endproperty
  a_empty_only_after_limit: assert property (p_empty_only_after_limit)
    else $error("empty tape set before the erased length limit");

  property p_flux_clears_count;
    @(posedge clk_i) disable iff (reset_i)
      rd_active_i && rd_flux_i |=> erase_reg == 32'd0;
  endproperty
  a_flux_clears_count: assert property (p_flux_clears_count)
    else $error("erased run not restarted by flux");

  c_tape_mark: cover property (@(posedge clk_i) disable iff (reset_i) tape_mark_o);

endmodule
`default_nettype wire

//--- src/tbf_formatter.sv
// Tape block formatter top: write framing for PE and GCR, read monitor
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module tbf_formatter
  import tbf_pkg::*;
#(
  parameter int PE_GAP     = PE_GAP_CYC,
  parameter int GCR_GAP    = GCR_GAP_CYC,
  parameter int TM_GAP     = GCR_TM_GAP_CYC,
  parameter int INIT_GAP   = PE_INIT_GAP_CYC,
  parameter int ID_LEN     = ARA_ID_CYC,
  parameter int PE_EMPTY   = PE_EMPTY_CYC,
  parameter int GCR_EMPTY  = GCR_EMPTY_CYC
)(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // Mode selection
  input  var  tbf_mode_e  mode_i,
  // Host commands
  input  var  tbf_cmd_s   cmd_i,
  output logic            cmd_ready_o,
  output logic            cmd_reject_o,
  // Host write data
  input  wire logic       data_valid_i,
  input  wire logic [7:0] data_i,
  input  wire logic [7:0] ecc_i,
  output logic            data_ready_o,
  // Head write side, one character per enable
  input  wire logic       char_en_i,
  output tbf_char_s       wr_char_o,
  output logic            wr_gap_o,
  // Head read side
  input  wire logic       rd_active_i,
  input  wire logic       rd_strobe_i,
  input  wire logic [8:0] rd_tracks_i,
  input  wire logic       rd_flux_i,
  output logic            empty_tape_o,
  output logic            tape_mark_o
);

  typedef enum logic [3:0] {
    S_IDLE, S_BOT_GAP, S_ID_BURST, S_ARA_GAP, S_ARA_ONES, S_ARA_ID,
    S_PREAMBLE, S_SYNC, S_DATA, S_ECC, S_RESYNC, S_TM_GAP, S_TM, S_GAP
  } tbf_state_e;

  tbf_state_e  state_reg, state_next;
  tbf_mode_e   mode_reg, mode_next;
  logic [31:0] cnt_reg, cnt_next;
  logic [15:0] left_reg, left_next;
  logic [2:0]  pos_reg, pos_next;
  logic [7:0]  grp_reg, grp_next;
  logic [10:0] bytes_reg, bytes_next;
  tbf_char_s   chr_reg, chr_next;
  logic        gap_reg, gap_next;
  logic        rej_reg, rej_next;
  logic        gcr;

  assign gcr = (mode_reg == TBF_MODE_GCR);

  // ----------------------------------------------------------------
  // Write sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    mode_next  = mode_reg;
    cnt_next   = cnt_reg;
    left_next  = left_reg;
    pos_next   = pos_reg;
    grp_next   = grp_reg;
    bytes_next = bytes_reg;
    chr_next   = '0;
    gap_next   = gap_reg;
    rej_next   = 1'b0;
    case (state_reg)
      S_IDLE:
      begin
        gap_next = 1'b0;
        if (cmd_i.valid)
        begin
          mode_next = mode_i;
          cnt_next  = '0;
          case (cmd_i.cmd)
            TBF_CMD_WRITE:
              if (cmd_i.length == 16'h0000)
                rej_next = 1'b1;
              else
              begin
                left_next  = cmd_i.length;
                state_next = (mode_i == TBF_MODE_GCR) ? S_PREAMBLE : S_PREAMBLE;
              end
            TBF_CMD_ERASE_GAP:
              state_next = S_GAP;
            TBF_CMD_MARK:
              state_next = (mode_i == TBF_MODE_GCR) ? S_TM_GAP : S_GAP;
            TBF_CMD_BOT:
              state_next = (mode_i == TBF_MODE_GCR) ? S_ID_BURST : S_BOT_GAP;
            default:
              state_next = S_IDLE;
          endcase
        end
      end
      S_BOT_GAP:
      begin
        gap_next = 1'b1;
        cnt_next = cnt_reg + 32'd1;
        if (cnt_reg + 32'd1 >= 32'(INIT_GAP))
          state_next = S_IDLE;
      end
      S_ID_BURST, S_ARA_ONES:
        if (char_en_i)
        begin
          gap_next = 1'b0;
          chr_next = '{valid: 1'b1,
                       tracks: (state_reg == S_ID_BURST) ? TRK_GCR_ID : TRK_ALL,
                       is_ecc: 1'b0};
          cnt_next = cnt_reg + 32'd1;
          if (cnt_reg + 32'd1 >= 32'(ID_LEN))
          begin
            cnt_next   = '0;
            state_next = (state_reg == S_ID_BURST) ? S_ARA_GAP : S_ARA_ID;
          end
        end
      S_ARA_GAP:
      begin
        gap_next = 1'b1;
        cnt_next = cnt_reg + 32'd1;
        if (cnt_reg + 32'd1 >= 32'(GCR_GAP))
        begin
          cnt_next   = '0;
          state_next = S_ARA_ONES;
        end
      end
      S_ARA_ID:
      begin
        gap_next = 1'b0;
        cnt_next = cnt_reg + 32'd1;
        if (char_en_i)
          chr_next = '{valid: 1'b1, tracks: TRK_ARA_ID, is_ecc: 1'b0};
        if (cnt_reg + 32'd1 >= 32'(ID_LEN))
        begin
          cnt_next   = '0;
          state_next = S_GAP;
        end
      end
      S_PREAMBLE:
        if (char_en_i)
        begin
          gap_next = 1'b0;
          chr_next = '{valid: 1'b1, tracks: gcr ? TRK_ALL : TRK_ERASED, is_ecc: 1'b0};
          cnt_next = cnt_reg + 32'd1;
          if (!gcr && cnt_reg + 32'd1 >= 32'(PE_PRE_ZEROS))
            state_next = S_SYNC;
          else if (gcr && cnt_reg + 32'd1 >= 32'(GCR_PRE_BYTES))
          begin
            state_next = S_DATA;
            pos_next   = '0;
            grp_next   = '0;
            bytes_next = '0;
          end
        end
      S_SYNC:
        if (char_en_i)
        begin
          chr_next   = '{valid: 1'b1, tracks: TRK_ALL, is_ecc: 1'b0};
          state_next = S_DATA;
        end
      S_DATA:
        if (char_en_i && data_valid_i)
        begin
          chr_next   = '{valid: 1'b1, tracks: {^~data_i, data_i}, is_ecc: 1'b0};
          left_next  = left_reg - 16'd1;
          pos_next   = pos_reg + 3'd1;
          bytes_next = bytes_reg + 11'd1;
          if (gcr && (pos_reg == 3'(GCR_GRP_DATA - 1) || left_reg == 16'd1))
            state_next = S_ECC;
          else if (left_reg == 16'd1)
          begin
            cnt_next   = '0;
            state_next = S_GAP;
          end
        end
      S_ECC:
        if (char_en_i)
        begin
          chr_next = '{valid: 1'b1, tracks: {^~ecc_i, ecc_i}, is_ecc: 1'b1};
          pos_next = '0;
          grp_next = grp_reg + 8'd1;
          cnt_next = '0;
          if (left_reg == 16'd0)
            state_next = S_GAP;
          else if (grp_reg + 8'd1 >= 8'(GCR_MAX_GROUPS)
                   || bytes_reg >= 11'(GCR_RESYNC_BYTES))
            state_next = S_RESYNC;
          else
            state_next = S_DATA;
        end
      S_RESYNC:
        if (char_en_i)
        begin
          chr_next = '{valid: 1'b1, tracks: TRK_RESYNC, is_ecc: 1'b0};
          cnt_next = cnt_reg + 32'd1;
          if (cnt_reg + 32'd1 >= 32'(GCR_PRE_BYTES))
          begin
            grp_next   = '0;
            bytes_next = '0;
            state_next = S_DATA;
          end
        end
      S_TM_GAP:
      begin
        gap_next = 1'b1;
        cnt_next = cnt_reg + 32'd1;
        if (cnt_reg + 32'd1 >= 32'(TM_GAP))
        begin
          cnt_next   = '0;
          state_next = S_TM;
        end
      end
      S_TM:
        if (char_en_i)
        begin
          gap_next = 1'b0;
          chr_next = '{valid: 1'b1, tracks: TRK_ZONE1 | TRK_ZONE2, is_ecc: 1'b0};
          cnt_next = cnt_reg + 32'd1;
          if (cnt_reg + 32'd1 >= 32'(TM_FLUX_COUNT))
          begin
            cnt_next   = '0;
            state_next = S_GAP;
          end
        end
      S_GAP:
      begin
        gap_next = 1'b1;
        cnt_next = cnt_reg + 32'd1;
        if (cnt_reg + 32'd1 >= (gcr ? 32'(GCR_GAP) : 32'(PE_GAP)))
          state_next = S_IDLE;
      end
      default:
        state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state_reg <= S_IDLE;
      mode_reg  <= TBF_MODE_PE;
      cnt_reg   <= '0;
      left_reg  <= '0;
      pos_reg   <= '0;
      grp_reg   <= '0;
      bytes_reg <= '0;
      chr_reg   <= '0;
      gap_reg   <= 1'b0;
      rej_reg   <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      mode_reg  <= mode_next;
      cnt_reg   <= cnt_next;
      left_reg  <= left_next;
      pos_reg   <= pos_next;
      grp_reg   <= grp_next;
      bytes_reg <= bytes_next;
      chr_reg   <= chr_next;
      gap_reg   <= gap_next;
      rej_reg   <= rej_next;
    end
  end

  // Past end of tape the host alone limits work, so no EOT input exists
  assign cmd_ready_o  = (state_reg == S_IDLE);
  assign cmd_reject_o = rej_reg;
  assign data_ready_o = (state_reg == S_DATA) && char_en_i;
  assign wr_char_o    = chr_reg;
  assign wr_gap_o     = gap_reg;

  // ----------------------------------------------------------------
  // Read monitor
  // ----------------------------------------------------------------
  tbf_tape_reader #(
    .PE_EMPTY  (PE_EMPTY),
    .GCR_EMPTY (GCR_EMPTY)
  ) u_reader (
    .clk_i        (clk_i),
    .reset_i      (reset_i),
    .rd_active_i  (rd_active_i),
    .mode_i       (mode_i),
    .rd_strobe_i  (rd_strobe_i),
    .rd_tracks_i  (rd_tracks_i),
    .rd_flux_i    (rd_flux_i),
    .empty_tape_o (empty_tape_o),
    .tape_mark_o  (tape_mark_o)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_zero_len_reject;
    @(posedge clk_i) disable iff (reset_i)
      state_reg == S_IDLE && cmd_i.valid && cmd_i.cmd == TBF_CMD_WRITE
        && cmd_i.length == 16'h0000 |=> cmd_reject_o && state_reg == S_IDLE;
  endproperty
  a_zero_len_reject: assert property (p_zero_len_reject)
    else $error("zero length write not refused");

  property p_pe_gap_len;
    @(posedge clk_i) disable iff (reset_i)
      state_reg == S_GAP && state_next == S_IDLE && !gcr |-> cnt_reg + 32'd1 == 32'(PE_GAP);
  endproperty
  a_pe_gap_len: assert property (p_pe_gap_len)
    else $error("PE gap length wrong");

  property p_gcr_gap_len;
    @(posedge clk_i) disable iff (reset_i)
      state_reg == S_GAP && state_next == S_IDLE && gcr |-> cnt_reg + 32'd1 == 32'(GCR_GAP);
  endproperty
  a_gcr_gap_len: assert property (p_gcr_gap_len)
    else $error("GCR gap length wrong");

  property p_tm_gap_len;
    @(posedge clk_i) disable iff (reset_i)
      state_reg == S_TM_GAP && state_next == S_TM |-> cnt_reg + 32'd1 == 32'(TM_GAP);
  endproperty
  a_tm_gap_len: assert property (p_tm_gap_len)
    else $error("tape mark gap length wrong");

  property p_tm_pattern;
    @(posedge clk_i) disable iff (reset_i)
      state_reg == S_TM && char_en_i |=> wr_char_o.tracks == (TRK_ZONE1 | TRK_ZONE2);
  endproperty
  a_tm_pattern: assert property (p_tm_pattern)
    else $error("tape mark track pattern wrong");

  property p_pe_sync_after_zeros;
    @(posedge clk_i) disable iff (reset_i)
      state_reg == S_PREAMBLE && state_next == S_SYNC
        |-> cnt_reg + 32'd1 == 32'(PE_PRE_ZEROS) && !gcr;
  endproperty
  a_pe_sync_after_zeros: assert property (p_pe_sync_after_zeros)
    else $error("PE preamble length wrong");

  property p_ecc_after_seven;
    @(posedge clk_i) disable iff (reset_i)
      state_reg == S_DATA && state_next == S_ECC && left_reg != 16'd1
        |-> pos_reg == 3'(GCR_GRP_DATA - 1);
  endproperty
  a_ecc_after_seven: assert property (p_ecc_after_seven)
    else $error("ECC byte out of position");

  property p_group_limit;
    @(posedge clk_i) disable iff (reset_i)
      grp_reg <= 8'(GCR_MAX_GROUPS);
  endproperty
  a_group_limit: assert property (p_group_limit)
    else $error("more than the allowed contiguous groups");

  property p_id_burst_track;
    @(posedge clk_i) disable iff (reset_i)
      state_reg == S_ID_BURST && char_en_i |=> wr_char_o.tracks == TRK_GCR_ID;
  endproperty
  a_id_burst_track: assert property (p_id_burst_track)
    else $error("ID burst not on track 6 only");

  c_write_block: cover property (@(posedge clk_i) disable iff (reset_i)
    state_reg == S_DATA ##1 state_reg == S_GAP);
  c_resync: cover property (@(posedge clk_i) disable iff (reset_i) state_reg == S_RESYNC);
  c_gcr_bot: cover property (@(posedge clk_i) disable iff (reset_i) state_reg == S_ARA_ID);
  c_reject: cover property (@(posedge clk_i) disable iff (reset_i) cmd_reject_o);

endmodule
`default_nettype wire

//--- tb/tbf_head_model.sv
// Head model: character clocking, write capture and read characters
`timescale 1ns/1ps
`default_nettype none
module tbf_head_model
  import tbf_pkg::*;
(
  // Clock
  input  wire logic       clk_i,
  // Write side
  output logic            char_en_o,
  input  var  tbf_char_s  wr_char_i,
  // Read side
  output logic            rd_strobe_o,
  output logic [8:0]      rd_tracks_o,
  output logic            rd_flux_o
);
  tbf_char_s  q[$];
  int         ph = 0;

  initial
  begin
    char_en_o   = 1'b0;
    rd_strobe_o = 1'b0;
    rd_tracks_o = 9'h000;
    rd_flux_o   = 1'b0;
  end

  // One character every third cycle, as the head clocking would give
  always @(negedge clk_i)
  begin
    ph = (ph == 2) ? 0 : ph + 1;
    char_en_o = (ph == 0);
  end

  always @(posedge clk_i)
    if (wr_char_i.valid === 1'b1)
      q.push_back(wr_char_i);

  // Tracks show the inverse once the strobe is gone, so stale data never matches
  task automatic send(input logic [8:0] t);
    @(negedge clk_i);
    rd_strobe_o = 1'b1;
    rd_flux_o   = 1'b1;
    rd_tracks_o = t;
    @(negedge clk_i);
    rd_strobe_o = 1'b0;
    rd_flux_o   = 1'b0;
    rd_tracks_o = ~t;
  endtask
endmodule
`default_nettype wire

//--- tb/test_tape_block_formatter.sv
// Self-checking bench of the tape block formatter
`timescale 1ns/1ps
`default_nettype none
module test_tape_block_formatter;
  import tbf_pkg::*;
  localparam int PG = 60;
  localparam int GG = 40;
  logic clk_i = 1'b0, reset_i = 1'b1, data_valid_i = 1'b0, rd_active_i = 1'b0;
  logic cmd_ready_o, cmd_reject_o, data_ready_o, char_en_i, wr_gap_o;
  logic empty_tape_o, tape_mark_o, rd_strobe_i, rd_flux_i;
  logic [7:0] data_i = 8'h00, ecc_i = 8'h00;
  logic [8:0] rd_tracks_i;
  tbf_mode_e mode_i = TBF_MODE_GCR;
  tbf_cmd_s  cmd_i = '0;
  tbf_char_s wr_char_o;
  int fail_count = 0, n_checks = 0, gap_n, tm_n = 0, i, k, n;
  logic [7:0] b[$];

  tbf_formatter #(.PE_GAP(PG), .GCR_GAP(GG), .TM_GAP(100), .INIT_GAP(50), .ID_LEN(20),
    .PE_EMPTY(200), .GCR_EMPTY(120)) tbf_formatter_i (.clk_i(clk_i), .reset_i(reset_i),
    .mode_i(mode_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .cmd_reject_o(cmd_reject_o),
    .data_valid_i(data_valid_i), .data_i(data_i), .ecc_i(ecc_i), .data_ready_o(data_ready_o),
    .char_en_i(char_en_i), .wr_char_o(wr_char_o), .wr_gap_o(wr_gap_o),
    .rd_active_i(rd_active_i), .rd_strobe_i(rd_strobe_i), .rd_tracks_i(rd_tracks_i),
    .rd_flux_i(rd_flux_i), .empty_tape_o(empty_tape_o), .tape_mark_o(tape_mark_o));
  tbf_head_model tbf_head_model_i (.clk_i(clk_i), .char_en_o(char_en_i),
    .wr_char_i(wr_char_o), .rd_strobe_o(rd_strobe_i), .rd_tracks_o(rd_tracks_i),
    .rd_flux_o(rd_flux_i));

  initial
  begin
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
    if (tape_mark_o === 1'b1)
      tm_n++;

  // Track pattern of a data byte: odd parity on track 9
  function automatic logic [8:0] trk(input logic [7:0] v);
    return {~^v, v};
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Issue one command, feed its bytes, then count gap cycles until idle
  task automatic run(input tbf_cmd_e c, input logic [15:0] len);
    tbf_head_model_i.q.delete();
    @(negedge clk_i);
    cmd_i = '{valid: 1'b1, cmd: c, length: len};
    @(negedge clk_i);
    cmd_i.valid = 1'b0;
    for (int j = 0; j < b.size(); j++)
    begin
      data_valid_i = 1'b1;
      data_i = b[j];
      k = 0;
      do begin @(posedge clk_i); k++; end while (data_ready_o !== 1'b1 && k < 5000);
      if (k >= 5000)
        fail_count++;
      @(negedge clk_i);
    end
    data_valid_i = 1'b0;
    gap_n = 0;
    k = 0;
    while (cmd_ready_o !== 1'b1 && k < 20000)
    begin
      @(posedge clk_i);
      k++;
      if (wr_gap_o === 1'b1)
        gap_n++;
    end
    if (k >= 20000)
      fail_count++;
    @(negedge clk_i);
  endtask

  initial
  begin
    #2_000_000;
    fail_count++;
    report_and_stop();
  end

  initial
  begin
    void'($urandom(56));
    ecc_i = $urandom;
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'b0;
    @(negedge clk_i);
    chk(cmd_ready_o, 1);
    // GCR beginning of tape: ID burst, reference burst, ID character
    run(TBF_CMD_BOT, 0);
    chk(tbf_head_model_i.q[0].tracks, TRK_GCR_ID);
    chk(tbf_head_model_i.q[20].tracks, TRK_ALL);
    chk(tbf_head_model_i.q[$].tracks, TRK_ARA_ID);
    // Zero-length writes refused in both modes
    for (i = 0; i < 2; i++)
    begin
      mode_i = tbf_mode_e'(i);
      @(negedge clk_i);
      cmd_i = '{valid: 1'b1, cmd: TBF_CMD_WRITE, length: 16'h0000};
      @(negedge clk_i);
      cmd_i.valid = 1'b0;
      chk(cmd_reject_o, 1);
      @(negedge clk_i);
      chk(cmd_ready_o, 1);
    end
    // PE block of random length 1 to 3
    mode_i = TBF_MODE_PE;
    n = 1 + $urandom_range(2);
    b.delete();
    for (i = 0; i < n; i++)
      b.push_back($urandom);
    run(TBF_CMD_WRITE, 16'(n));
    chk(16'(tbf_head_model_i.q.size()), 16'(41 + n));
    for (i = 0; i < 40; i++)
      chk(tbf_head_model_i.q[i].tracks, TRK_ERASED);
    chk(tbf_head_model_i.q[40].tracks, TRK_ALL);
    for (i = 0; i < n; i++)
      chk(tbf_head_model_i.q[41 + i].tracks, trk(b[i]));
    chk(gap_n >= PG * 5 / 6 && gap_n <= PG + 3, 1);
    // GCR block of nine bytes: one full group and a short one
    mode_i = TBF_MODE_GCR;
    b.delete();
    for (i = 0; i < 9; i++)
      b.push_back($urandom);
    run(TBF_CMD_WRITE, 16'd9);
    chk(16'(tbf_head_model_i.q.size()), 16'(GCR_PRE_BYTES + 11));
    for (i = 0; i < 7; i++)
      chk(tbf_head_model_i.q[GCR_PRE_BYTES + i].tracks, trk(b[i]));
    chk(tbf_head_model_i.q[GCR_PRE_BYTES + 7].is_ecc, 1);
    chk(tbf_head_model_i.q[GCR_PRE_BYTES + 6].is_ecc, 0);
    chk(tbf_head_model_i.q[$].is_ecc, 1);
    chk(gap_n >= GG * 285 / 300 && gap_n <= GG + 3, 1);
    // Long GCR record: the group limit forces a resync burst
    b.delete();
    for (i = 0; i < 1110; i++)
      b.push_back($urandom);
    run(TBF_CMD_WRITE, 16'd1110);
    n = GCR_PRE_BYTES + GCR_MAX_GROUPS * 8;
    chk(16'(tbf_head_model_i.q.size()), 16'(n + GCR_PRE_BYTES + 5));
    chk(tbf_head_model_i.q[n - 1].is_ecc, 1);
    chk(tbf_head_model_i.q[n].tracks, TRK_RESYNC);
    chk(tbf_head_model_i.q[n + GCR_PRE_BYTES].tracks, trk(b[GCR_MAX_GROUPS * 7]));
    // GCR tape mark, then a PE erase gap and a PE beginning of tape
    b.delete();
    run(TBF_CMD_MARK, 16'h0000);
    chk(16'(tbf_head_model_i.q.size()), 16'(TM_FLUX_COUNT));
    chk(tbf_head_model_i.q[0].tracks, TRK_ZONE1 | TRK_ZONE2);
    chk(gap_n >= 100 + GG * 285 / 300 && gap_n <= 100 + GG + 6, 1);
    mode_i = TBF_MODE_PE;
    run(TBF_CMD_ERASE_GAP, 16'h0000);
    chk(gap_n >= PG * 5 / 6 && gap_n <= PG + 3, 1);
    run(TBF_CMD_BOT, 16'h0000);
    chk(16'(tbf_head_model_i.q.size()), 16'h0000);
    chk(gap_n >= 50 && gap_n <= 53, 1);
    // Erased runs: the GCR limit is the shorter one
    mode_i = TBF_MODE_PE;
    rd_active_i = 1'b1;
    repeat (130) @(negedge clk_i);
    chk(empty_tape_o, 0);
    repeat (90) @(negedge clk_i);
    chk(empty_tape_o, 1);
    rd_active_i = 1'b0;
    repeat (3) @(negedge clk_i);
    chk(empty_tape_o, 0);
    mode_i = TBF_MODE_GCR;
    rd_active_i = 1'b1;
    repeat (130) @(negedge clk_i);
    chk(empty_tape_o, 1);
    // Tape mark patterns
    n = tm_n;
    tbf_head_model_i.send(TRK_ZONE1);
    repeat (4) @(negedge clk_i);
    chk(16'(tm_n - n), 1);
    tbf_head_model_i.send(TRK_ZONE1 | TRK_ZONE3);
    repeat (4) @(negedge clk_i);
    chk(16'(tm_n - n), 1);
    tbf_head_model_i.send(TRK_ZONE2 | 9'h001);
    tbf_head_model_i.send(TRK_ZONE2 | 9'h001);
    repeat (4) @(negedge clk_i);
    chk(16'(tm_n - n), 2);
    report_and_stop();
  end
endmodule
`default_nettype wire
